// ===== rtl/beo_pkg.sv
package beo_pkg;
  // Values after reset
  localparam logic BEO_PREV_RST = 1'b0;
  localparam logic BEO_BIT_RST = 1'b0;
  // Default number of edge and latch instances
  localparam int BEO_N_EDGE = 4;
  localparam int BEO_N_LATCH = 4;
  // Operation select for a set/clear/coil slot
  typedef enum logic [1:0] {
    BEO_OP_SET = 2'b00,
    BEO_OP_CLR = 2'b01,
    BEO_OP_OUT = 2'b10,
    BEO_OP_OUTN = 2'b11
  } beo_op_type;
endpackage : beo_pkg

// ===== rtl/beo_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carrier for one bank of edge detectors
interface beo_edge_if #(parameter int N = 4);
  logic [N-1:0] cond;
  logic [N-1:0] enable;
  logic [N-1:0] falling;
  logic [N-1:0] pulse;
  modport core (input cond, input enable, input falling, output pulse);
  modport user (output cond, output enable, output falling, input pulse);
endinterface : beo_edge_if
`default_nettype wire

// ===== rtl/beo_edge.sv
`timescale 1ns/1ps
`default_nettype none
module beo_edge import beo_pkg::*; #(
  parameter int N = BEO_N_EDGE
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bank
  beo_edge_if.core eif
);
  // ==========================================================
  // Edge memory, one detector per instance
  logic [N-1:0] prev_r;
  logic [N-1:0] prev_nxt;
  logic [N-1:0] pul_r;
  logic [N-1:0] pul_nxt;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_det
      // Disabled: hold memory, so the compare resumes after release
      always_comb begin
        prev_nxt[g] = eif.enable[g] ? eif.cond[g] : prev_r[g];
        if (!eif.enable[g]) begin
          pul_nxt[g] = pul_r[g];
        end else if (eif.falling[g]) begin
          pul_nxt[g] = prev_r[g] & ~eif.cond[g];
        end else begin
          pul_nxt[g] = ~prev_r[g] & eif.cond[g];
        end
      end
    end
  endgenerate
  // Registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= '0;
      pul_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      pul_r <= pul_nxt;
    end
  end
  assign eif.pulse = pul_r;
  // ==========================================================
  // Checks
  a_pulse_one_scan: assert property (@(posedge clk_i) disable iff (rst_i)
    (pul_r != '0) ##1 ($past(eif.enable) == {N{1'b1}}) |-> ((pul_r & $past(pul_r)) == '0))
    else $error("edge pulse longer than one scan");
  a_prev_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (eif.enable == '0) |=> (prev_r == $past(prev_r)))
    else $error("edge memory changed while disabled");
  c_rise: cover property (@(posedge clk_i) disable iff (rst_i) pul_r[0] && !eif.falling[0]);
endmodule : beo_edge
`default_nettype wire

// ===== rtl/beo_latch.sv
`timescale 1ns/1ps
`default_nettype none
module beo_latch import beo_pkg::*; #(
  parameter int N = BEO_N_LATCH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Latch inputs
  input wire logic [N-1:0] set_i,
  input wire logic [N-1:0] rst_in_i,
  input wire logic [N-1:0] enable_i,
  // Latch bits
  output logic [N-1:0] q_o
);
  // ==========================================================
  // Latching relays; reset wins when both inputs are on
  logic [N-1:0] q_r;
  logic [N-1:0] q_nxt;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lat
      always_comb begin
        if (!enable_i[g]) begin
          q_nxt[g] = q_r[g];
        end else if (rst_in_i[g]) begin
          q_nxt[g] = 1'b0;
        end else if (set_i[g]) begin
          q_nxt[g] = 1'b1;
        end else begin
          q_nxt[g] = q_r[g];
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign q_o = q_r;
  a_latch_reset_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable_i[0] && rst_in_i[0]) |=> !q_r[0])
    else $error("latch not cleared by reset input");
  a_latch_hold_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (!enable_i[0]) |=> (q_r[0] == $past(q_r[0])))
    else $error("latch changed while interlocked");
  c_latch_set: cover property (@(posedge clk_i) disable iff (rst_i) $rose(q_r[0]));
endmodule : beo_latch
`default_nettype wire

// ===== rtl/beo_top.sv
`timescale 1ns/1ps
`default_nettype none
module beo_top import beo_pkg::*; #(
  parameter int NE = BEO_N_EDGE,
  parameter int NL = BEO_N_LATCH,
  parameter int NB = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Scan strobe: one pulse per program scan
  input wire logic scan_i,
  // Edge instances
  input wire logic [NE-1:0] edge_cond_i,
  input wire logic [NE-1:0] edge_en_i,
  input wire logic [NE-1:0] edge_fall_i,
  // Latch instances
  input wire logic [NL-1:0] lat_set_i,
  input wire logic [NL-1:0] lat_rst_i,
  input wire logic [NL-1:0] lat_en_i,
  input wire logic [NL-1:0] lat_retain_i,
  // Power restart: clear non-retentive latches only
  input wire logic restart_i,
  // Bit slots
  input wire logic [NB-1:0] bit_cond_i,
  input wire logic [NB-1:0] bit_en_i,
  input wire logic [2*NB-1:0] bit_op_i,
  // Results
  output logic [NE-1:0] edge_pulse_o,
  output logic [NL-1:0] lat_q_o,
  output logic [NB-1:0] bit_q_o
);
  // ==========================================================
  // Scan gating: instances act only on a scan strobe, except restart clearing non-retentive latches
  beo_edge_if #(.N(NE)) eif ();
  assign eif.cond = edge_cond_i;
  assign eif.enable = edge_en_i & {NE{scan_i}};
  assign eif.falling = edge_fall_i;
  beo_edge #(.N(NE)) u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .eif(eif)
  );
  assign edge_pulse_o = eif.pulse;
  // ==========================================================
  // Latches; restart pulls non-retentive ones through reset input
  logic [NL-1:0] lat_q;
  logic [NL-1:0] lat_r_eff;
  logic [NL-1:0] lat_e_eff;
  assign lat_r_eff = lat_rst_i | (~lat_retain_i & {NL{restart_i}});
  assign lat_e_eff = (lat_en_i & {NL{scan_i}}) | (~lat_retain_i & {NL{restart_i}});
  beo_latch #(.N(NL)) u_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(lat_set_i),
    .rst_in_i(lat_r_eff),
    .enable_i(lat_e_eff),
    .q_o(lat_q)
  );
  assign lat_q_o = lat_q;
  // ==========================================================
  // Set, clear and coil slots; no flag outputs exist at all
  logic [NB-1:0] bit_r;
  logic [NB-1:0] bit_nxt;
  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_bit
      beo_op_type op;
      assign op = beo_op_type'(bit_op_i[2*g +: 2]);
      always_comb begin
        bit_nxt[g] = bit_r[g];
        if (scan_i && bit_en_i[g]) begin
          case (op)
            BEO_OP_SET: bit_nxt[g] = bit_cond_i[g] ? 1'b1 : bit_r[g];
            BEO_OP_CLR: bit_nxt[g] = bit_cond_i[g] ? 1'b0 : bit_r[g];
            BEO_OP_OUT: bit_nxt[g] = bit_cond_i[g];
            BEO_OP_OUTN: bit_nxt[g] = ~bit_cond_i[g];
            default: bit_nxt[g] = bit_r[g];
          endcase
        end else if (scan_i && (op == BEO_OP_OUT || op == BEO_OP_OUTN)) begin
          // Interlocked coil turns off; set/clear hold
          bit_nxt[g] = 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_r <= '0;
    end else begin
      bit_r <= bit_nxt;
    end
  end
  assign bit_q_o = bit_r;
  a_set_forces_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (scan_i && bit_en_i[0] && bit_cond_i[0] && bit_op_i[1:0] == BEO_OP_SET) |=> bit_r[0])
    else $error("set did not force bit on");
  a_clear_forces_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (scan_i && bit_en_i[0] && bit_cond_i[0] && bit_op_i[1:0] == BEO_OP_CLR) |=> !bit_r[0])
    else $error("clear did not force bit off");
  a_setclr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!bit_en_i[0] && !bit_op_i[1]) |=> (bit_r[0] == $past(bit_r[0])))
    else $error("set/clear bit changed while disabled");
  a_coil_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (scan_i && bit_en_i[0] && bit_op_i[1:0] == BEO_OP_OUTN) |=> (bit_r[0] == !$past(bit_cond_i[0])))
    else $error("inverted coil wrong");
  a_retain_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (restart_i && lat_retain_i[0] && !(scan_i && lat_en_i[0])) |=> (lat_q[0] == $past(lat_q[0])))
    else $error("retentive latch lost at restart");
  c_coil_on: cover property (@(posedge clk_i) disable iff (rst_i) $rose(bit_r[0]));
endmodule : beo_top
`default_nettype wire

// ===== test/bit_edge_and_latch_ops_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bit_edge_and_latch_ops_tb_top import beo_pkg::*; ;
  // ==========================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scan_i = 1'b0;
  logic restart_i = 1'b0;
  logic [3:0] edge_cond_i = 4'h0, edge_en_i = 4'h0, edge_fall_i = 4'h0;
  logic [3:0] lat_set_i = 4'h0, lat_rst_i = 4'h0, lat_en_i = 4'h0, lat_retain_i = 4'h0;
  logic [3:0] bit_cond_i = 4'h0, bit_en_i = 4'h0;
  logic [7:0] bit_op_i = 8'h00;
  logic [3:0] edge_pulse_o, lat_q_o, bit_q_o;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  beo_top uut (.clk_i(clk_i), .rst_i(rst_i), .scan_i(scan_i), .edge_cond_i(edge_cond_i),
    .edge_en_i(edge_en_i), .edge_fall_i(edge_fall_i), .lat_set_i(lat_set_i), .lat_rst_i(lat_rst_i),
    .lat_en_i(lat_en_i), .lat_retain_i(lat_retain_i), .restart_i(restart_i), .bit_cond_i(bit_cond_i),
    .bit_en_i(bit_en_i), .bit_op_i(bit_op_i), .edge_pulse_o(edge_pulse_o), .lat_q_o(lat_q_o),
    .bit_q_o(bit_q_o));

  // ==========================================
  // Shared tasks
  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk

  // One scan: inputs were set at the falling edge, result read at the next one
  task automatic step();
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : step

  // Hang guard, far above the about 32 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================
  // Scenarios
  task automatic t_edge();
    edge_en_i = 4'hf; edge_fall_i = 4'hc; edge_cond_i = 4'h0; step(); chk(edge_pulse_o, 4'h0);
    edge_cond_i = 4'hf; step(); chk(edge_pulse_o, 4'h3);
    step(); chk(edge_pulse_o, 4'h0);
    edge_cond_i = 4'h0; step(); chk(edge_pulse_o, 4'hc);
    step(); chk(edge_pulse_o, 4'h0);
  endtask : t_edge

  // Interlocked instance must not see the dip while disabled
  task automatic t_freeze();
    edge_fall_i = 4'h0; edge_cond_i = 4'hf; step();
    step(); chk(edge_pulse_o, 4'h0);
    edge_en_i = 4'h0; edge_cond_i = 4'h0; step(); chk(edge_pulse_o, 4'h0);
    edge_en_i = 4'hf; edge_cond_i = 4'hf; step(); chk(edge_pulse_o, 4'h0);
  endtask : t_freeze

  // No scan strobe: the dip must not reach the edge memory either
  task automatic t_scan();
    scan_i = 1'b0; edge_cond_i = 4'h0; step(); chk(edge_pulse_o, 4'h0);
    scan_i = 1'b1; edge_cond_i = 4'hf; step(); chk(edge_pulse_o, 4'h0);
  endtask : t_scan

  // Slots: set, clear, coil, inverted coil, then clear and set swapped
  task automatic t_bits();
    bit_en_i = 4'hf; bit_op_i = 8'he4; bit_cond_i = 4'hf; step(); chk(bit_q_o, 4'h5);
    bit_cond_i = 4'h0; step(); chk(bit_q_o, 4'h9);
    bit_op_i = 8'he1; bit_cond_i = 4'hf; step(); chk(bit_q_o, 4'h6);
    bit_en_i = 4'h0; bit_cond_i = 4'h0; step(); chk(bit_q_o, 4'h2);
    bit_en_i = 4'hf; bit_op_i = 8'h1b; bit_cond_i = 4'ha; step(); chk(bit_q_o, 4'hb);
  endtask : t_bits

  task automatic t_latch();
    lat_en_i = 4'hf; lat_retain_i = 4'h3; lat_set_i = 4'hf; step(); chk(lat_q_o, 4'hf);
    lat_set_i = 4'h0; step(); chk(lat_q_o, 4'hf);
    lat_rst_i = 4'hf; step(); chk(lat_q_o, 4'h0);
    lat_rst_i = 4'h0; step(); chk(lat_q_o, 4'h0);
    lat_set_i = 4'hf; lat_rst_i = 4'h5; step(); chk(lat_q_o, 4'ha);
    lat_rst_i = 4'h0; step(); chk(lat_q_o, 4'hf);
    lat_en_i = 4'h0; lat_set_i = 4'h0; lat_rst_i = 4'hf; step(); chk(lat_q_o, 4'hf);
    lat_rst_i = 4'h0; restart_i = 1'b1; step(); chk(lat_q_o, 4'h3);
    restart_i = 1'b0;
  endtask : t_latch

  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_i);
    chk(edge_pulse_o | lat_q_o | bit_q_o, 4'h0);
    rst_i = 1'b0;
    scan_i = 1'b1;
    t_edge();
    t_freeze();
    t_scan();
    t_bits();
    t_latch();
    finish_test();
  end
endmodule : bit_edge_and_latch_ops_tb_top
`default_nettype wire
